// File: rtl/ewg_pkg.sv
package ewg_pkg;
   // register indices and byte addresses
   localparam logic [7:0] EWG_CNT_IDX = 8'h28;
   localparam logic [7:0] EWG_MUL_IDX = 8'h2b;
   localparam logic [9:0] EWG_CNT_ADDR = {EWG_CNT_IDX, 2'b00};
   localparam logic [9:0] EWG_MUL_ADDR = {EWG_MUL_IDX, 2'b00};
   // field positions in region_wait_counts
   localparam int EWG_XPD_BIT = 15;
   localparam int EWG_IO_LSB = 12;
   localparam int EWG_DHI_LSB = 9;
   localparam int EWG_DLO_LSB = 6;
   localparam int EWG_PHI_LSB = 3;
   localparam int EWG_PLO_LSB = 0;
   localparam int EWG_DBL_BIT = 0;
   // reset values: seven waits everywhere, no doubling
   localparam logic [15:0] EWG_CNT_RST = 16'h7fff & 16'h7fff;
   localparam logic [15:0] EWG_MUL_RST = 16'h0000;
   localparam logic [3:0] EWG_MAX_WAIT = 4'he;
   // access spaces
   typedef enum logic [1:0] {
      EWG_SP_PROG = 2'b00,
      EWG_SP_DATA = 2'b01,
      EWG_SP_IO = 2'b10
   } ewg_space_t;
   typedef enum logic [1:0] {
      EWG_IDLE = 2'b00,
      EWG_WAIT = 2'b01,
      EWG_DONE = 2'b10
   } ewg_state_t;
endpackage

// File: rtl/ewg_counter.sv
`timescale 1ns/1ns
// cycle counter that holds the bus cycle for a loaded number of waits
module ewg_counter
   import ewg_pkg::*;
#(
   parameter int WIDTH = 4
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // control
   input wire logic load,
   input wire logic [WIDTH-1:0] load_val,
   // status
   output logic busy,
   output logic [WIDTH-1:0] count
);
   typedef struct packed {
      logic [WIDTH-1:0] cnt;
   } ewg_cnt_state_t;
   ewg_cnt_state_t st_reg;
   ewg_cnt_state_t st_next;

   // load wins over the running decrement
   always_comb begin
      st_next = st_reg;
      if (load) begin
         st_next.cnt = load_val;
      end else if (st_reg.cnt != '0) begin
         st_next.cnt = st_reg.cnt - WIDTH'(1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign busy = (st_reg.cnt != '0);
   assign count = st_reg.cnt;
endmodule

// File: rtl/ewg_wait_gen.sv
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module ewg_wait_gen
   import ewg_pkg::*;
#(
   parameter int ADDR_W = 23
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // register port
   input wire logic [9:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // access request from the core
   input wire logic acc_req,
   input wire logic [1:0] acc_space,
   input wire logic [ADDR_W-1:0] acc_addr,
   // access progress
   output logic acc_busy,
   output logic acc_done,
   output logic [3:0] acc_waits,
   output logic gen_clk_gated
);

   typedef struct packed {
      logic [15:0] cnt_reg;
      logic dbl_reg;
      logic [15:0] rdata;
      ewg_state_t state;
      logic [3:0] waits;
   } ewg_state_all_t;

   ewg_state_all_t st_reg;
   ewg_state_all_t st_next;

   logic [2:0] base_cnt;
   logic [3:0] scaled_cnt;
   logic all_zero;
   logic cnt_load;
   logic cnt_busy;
   logic [3:0] cnt_val;
   logic xpd;

   //////////////////////////////////////////////////////////////////////////
   // region decode
   assign xpd = st_reg.cnt_reg[EWG_XPD_BIT];

   // pick the base count for the access space and region
   always_comb begin
      base_cnt = st_reg.cnt_reg[EWG_PLO_LSB +: 3];
      unique case (acc_space)
         EWG_SP_IO: begin
            base_cnt = st_reg.cnt_reg[EWG_IO_LSB +: 3];
         end
         EWG_SP_DATA: begin
            if (acc_addr[15]) begin
               base_cnt = st_reg.cnt_reg[EWG_DHI_LSB +: 3];
            end else begin
               base_cnt = st_reg.cnt_reg[EWG_DLO_LSB +: 3];
            end
         end
         EWG_SP_PROG: begin
            // extended decode ignores the upper field entirely
            if (!xpd && acc_addr[15]) begin
               base_cnt = st_reg.cnt_reg[EWG_PHI_LSB +: 3];
            end else begin
               base_cnt = st_reg.cnt_reg[EWG_PLO_LSB +: 3];
            end
         end
         default: begin
            // the spare space code decodes exactly like program space
            if (!xpd && acc_addr[15]) begin
               base_cnt = st_reg.cnt_reg[EWG_PHI_LSB +: 3];
            end else begin
               base_cnt = st_reg.cnt_reg[EWG_PLO_LSB +: 3];
            end
         end
      endcase
   end

   // doubling by shift, max 14
   assign scaled_cnt = st_reg.dbl_reg ? {base_cnt, 1'b0} : {1'b0, base_cnt};

   // the upper program field counts only when it can be selected
   assign all_zero = (st_reg.cnt_reg[14:6] == 9'h000)
      && (st_reg.cnt_reg[2:0] == 3'h0)
      && (xpd || st_reg.cnt_reg[5:3] == 3'h0);

   //////////////////////////////////////////////////////////////////////////
   // state update
   always_comb begin
      st_next = st_reg;
      cnt_load = 1'b0;
      st_next.rdata = 16'h0000;
      if (reg_wr) begin
         if (reg_addr == EWG_CNT_ADDR) begin
            st_next.cnt_reg = reg_wdata;
         end
         if (reg_addr == EWG_MUL_ADDR) begin
            st_next.dbl_reg = reg_wdata[EWG_DBL_BIT]; // upper bits dropped
         end
      end
      if (reg_rd) begin
         if (reg_addr == EWG_CNT_ADDR) begin
            st_next.rdata = st_reg.cnt_reg;
         end else if (reg_addr == EWG_MUL_ADDR) begin
            st_next.rdata = {15'h0000, st_reg.dbl_reg};
         end
      end
      unique case (st_reg.state)
         EWG_IDLE: begin
            if (acc_req) begin
               st_next.waits = scaled_cnt;
               // zero waits skip the counter, which then never toggles
               if (scaled_cnt == 4'h0 || all_zero) begin
                  st_next.state = EWG_DONE;
               end else begin
                  cnt_load = 1'b1;
                  st_next.state = EWG_WAIT;
               end
            end
         end
         EWG_WAIT: begin
            // ready-line extension lies outside this block
            if (cnt_val == 4'h1) begin
               st_next.state = EWG_DONE;
            end
         end
         EWG_DONE: begin
            st_next.state = EWG_IDLE;
         end
         default: begin
            st_next.state = EWG_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         st_reg.cnt_reg <= EWG_CNT_RST; // seven everywhere
         st_reg.dbl_reg <= EWG_MUL_RST[EWG_DBL_BIT];
         st_reg.rdata <= 16'h0000;
         st_reg.state <= EWG_IDLE;
         st_reg.waits <= 4'h0;
      end else begin
         st_reg <= st_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // wait counter
   ewg_counter #(
      .WIDTH(4)
   ) u_cnt (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .load(cnt_load),
      .load_val(scaled_cnt),
      .busy(cnt_busy),
      .count(cnt_val)
   );

   assign reg_rdata = st_reg.rdata;
   assign acc_busy = (st_reg.state == EWG_WAIT);
   assign acc_done = (st_reg.state == EWG_DONE);
   assign acc_waits = st_reg.waits;
   assign gen_clk_gated = all_zero;

   //////////////////////////////////////////////////////////////////////////
   // checks
   // counts above fourteen are left to the ready line, so no check here
   // looks past a doubled seven; rewriting the counts mid-access is not
   // guarded, the running access keeps the count it loaded
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   // access length against the loaded count
   wait_len_a: assert property (
      acc_req && st_reg.state == EWG_IDLE && scaled_cnt == 4'h3
      |=> acc_busy [*3] ##1 acc_done)
      else $error("wait length wrong");
   wait_one_a: assert property (
      acc_req && st_reg.state == EWG_IDLE && scaled_cnt == 4'h1 |=> acc_busy ##1 acc_done)
      else $error("single wait length wrong");
   wait_seven_a: assert property (
      acc_req && st_reg.state == EWG_IDLE && scaled_cnt == 4'h7
      |=> acc_busy [*7] ##1 acc_done)
      else $error("seven wait length wrong");
   zero_wait_a: assert property (
      acc_req && st_reg.state == EWG_IDLE && scaled_cnt == 4'h0 |=> acc_done && !acc_busy)
      else $error("zero wait access held");

   // done is a lone pulse and never overlaps the wait cycles
   done_pulse_a: assert property (acc_done |=> !acc_done)
      else $error("done longer than one cycle");
   busy_done_a: assert property (!(acc_busy && acc_done))
      else $error("busy and done together");
   busy_cnt_a: assert property (acc_busy |-> cnt_busy)
      else $error("bus held with counter empty");
   busy_rise_a: assert property ($rose(acc_busy) |-> $past(acc_req))
      else $error("bus held without request");
   done_rise_a: assert property ($rose(acc_done) |-> $past(acc_busy) || $past(acc_req))
      else $error("done without access");

   // the reported count moves only when a request is taken
   waits_hold_a: assert property (
      !(acc_req && st_reg.state == EWG_IDLE) |=> $stable(acc_waits))
      else $error("wait count changed without request");

   // doubling stays even and within fourteen
   max_wait_a: assert property (acc_waits <= EWG_MAX_WAIT)
      else $error("wait count above fourteen");
   dbl_even_a: assert property (
      st_reg.dbl_reg && acc_req && st_reg.state == EWG_IDLE |=> acc_waits[0] == 1'b0)
      else $error("doubled count odd");
   dbl_scale_a: assert property (
      st_reg.dbl_reg && acc_req && st_reg.state == EWG_IDLE && acc_space == EWG_SP_IO
      |=> acc_waits == {$past(st_reg.cnt_reg[14:12]), 1'b0})
      else $error("io count not doubled");
   mul_wr_a: assert property (
      reg_wr && reg_addr == EWG_MUL_ADDR |=> st_reg.dbl_reg == $past(reg_wdata[EWG_DBL_BIT]))
      else $error("doubling bit not written");

   // register readback; nothing else is ever on the read bus
   mul_rsvd_a: assert property (
      reg_rd && reg_addr == EWG_MUL_ADDR |=> reg_rdata[15:1] == 15'h0000)
      else $error("reserved bits not zero");
   cnt_rd_a: assert property (
      reg_rd && reg_addr == EWG_CNT_ADDR |=> reg_rdata == $past(st_reg.cnt_reg))
      else $error("count register readback wrong");
   rd_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data without read");
   reset_seven_a: assert property (
      $rose(resetn) |-> st_reg.cnt_reg[14:0] == 15'h7fff)
      else $error("reset counts not seven");

   // gating: the counter must sit still and the access still completes
   gated_idle_a: assert property (gen_clk_gated |-> !cnt_busy)
      else $error("counter runs while gated");
   gated_done_a: assert property (
      acc_req && st_reg.state == EWG_IDLE && all_zero |=> acc_done)
      else $error("gated access not completed");

   // per-region field selection, undoubled
   io_sel_a: assert property (
      acc_req && st_reg.state == EWG_IDLE && acc_space == EWG_SP_IO && !st_reg.dbl_reg
      |=> acc_waits == {1'b0, $past(st_reg.cnt_reg[14:12])})
      else $error("io count wrong");
   dhi_sel_a: assert property (
      acc_req && st_reg.state == EWG_IDLE && acc_space == EWG_SP_DATA && acc_addr[15]
      && !st_reg.dbl_reg |=> acc_waits == {1'b0, $past(st_reg.cnt_reg[11:9])})
      else $error("upper data count wrong");
   dlo_sel_a: assert property (
      acc_req && st_reg.state == EWG_IDLE && acc_space == EWG_SP_DATA && !acc_addr[15]
      && !st_reg.dbl_reg |=> acc_waits == {1'b0, $past(st_reg.cnt_reg[8:6])})
      else $error("lower data count wrong");

   // program space follows the extended decode
   phi_sel_a: assert property (
      acc_req && st_reg.state == EWG_IDLE && acc_space == EWG_SP_PROG && acc_addr[15]
      && !xpd && !st_reg.dbl_reg |=> acc_waits == {1'b0, $past(st_reg.cnt_reg[5:3])})
      else $error("upper program count wrong");
   xpd_sel_a: assert property (
      acc_req && st_reg.state == EWG_IDLE && acc_space == EWG_SP_PROG && xpd
      && !st_reg.dbl_reg |=> acc_waits == {1'b0, $past(st_reg.cnt_reg[2:0])})
      else $error("extended program count wrong");
   phi_skip_a: assert property (
      acc_req && st_reg.state == EWG_IDLE && acc_space == EWG_SP_PROG && xpd && acc_addr[15]
      && st_reg.dbl_reg |=> acc_waits == {$past(st_reg.cnt_reg[2:0]), 1'b0})
      else $error("upper program field used while extended");
   spare_prog_a: assert property (
      acc_req && st_reg.state == EWG_IDLE && acc_space == 2'b11 && !xpd && !acc_addr[15]
      && !st_reg.dbl_reg |=> acc_waits == {1'b0, $past(st_reg.cnt_reg[2:0])})
      else $error("spare space count wrong");

   // main scenarios
   cov_double_c: cover property (st_reg.dbl_reg && acc_done && acc_waits == 4'he);
   cov_xpd_c: cover property (xpd && acc_req && acc_space == EWG_SP_PROG);
   cov_gated_c: cover property (gen_clk_gated && acc_done);
   cov_io_c: cover property (acc_req && st_reg.state == EWG_IDLE && acc_space == EWG_SP_IO);
   cov_spare_c: cover property (acc_req && st_reg.state == EWG_IDLE && acc_space == 2'b11);
endmodule

// File: sim/ewg_mem_model.sv
`timescale 1ns/1ns
// external memory side: measures how long each bus cycle is held
module ewg_mem_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // bus cycle progress
   input wire logic acc_busy,
   input wire logic acc_done,
   // measured hold
   output logic [4:0] busy_seen
);
   // counts held cycles; a slow part would lean on its own ready line
   always @(posedge ref_clk) begin
      if (!resetn || acc_done) busy_seen <= 5'h00;
      else if (acc_busy) busy_seen <= busy_seen + 5'h01;
   end
endmodule

// File: sim/tb.sv
`timescale 1ns/1ns
module tb;
   import ewg_pkg::*;
   logic ref_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, acc_req = 0, rd_d = 0;
   logic [9:0] reg_addr = 0;
   logic [15:0] reg_wdata = 0, reg_rdata, cnt, mul;
   logic [1:0] acc_space = 0;
   logic [22:0] acc_addr = 0;
   logic acc_busy, acc_done, gen_clk_gated;
   logic [3:0] acc_waits, ew;
   logic [4:0] busy_seen;
   logic [15:0] rq[$];
   logic [3:0] aq[$];
   int miscompares = 0, n_compared = 0, seed = 39;
   always #4 ref_clk = ~ref_clk;
   ewg_wait_gen u_dut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .acc_req(acc_req), .acc_space(acc_space), .acc_addr(acc_addr), .acc_busy(acc_busy),
      .acc_done(acc_done), .acc_waits(acc_waits), .gen_clk_gated(gen_clk_gated));
   ewg_mem_model u_mem (.ref_clk(ref_clk), .resetn(resetn), .acc_busy(acc_busy),
      .acc_done(acc_done), .busy_seen(busy_seen));
   //////////////////////////////////////////////////////////////////////////
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one compare task per kind of result
   task automatic chk_rd(logic [15:0] e, logic [15:0] g);
      chk("reg_rdata", e, g);
   endtask
   task automatic chk_acc(logic [3:0] e, logic [3:0] g);
      chk("acc_waits", {12'h000, e}, {12'h000, g});
   endtask
   task automatic chk_hold(logic [4:0] e, logic [4:0] g);
      chk("busy cycles", {11'h000, e}, {11'h000, g});
   endtask
   task automatic chk_lvl(string nm, logic e, logic g);
      chk(nm, {15'h0000, e}, {15'h0000, g});
   endtask
   task automatic end_of_test();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // expected scaled wait count for one access
   function automatic logic [3:0] exp_w(logic [15:0] c, logic m, logic [1:0] s, logic h);
      logic [2:0] b;
      if (s == 2'b10) b = c[14:12];
      else if (s == 2'b01) b = h ? c[11:9] : c[8:6];
      else b = (h && !c[15]) ? c[5:3] : c[2:0];
      return m ? {b, 1'b0} : {1'b0, b};
   endfunction
   //////////////////////////////////////////////////////////////////////////
   task automatic wr(logic [9:0] a, logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 0;
   endtask
   task automatic rd(logic [9:0] a, logic [15:0] e);
      @(posedge ref_clk);
      reg_rd <= 1; reg_addr <= a; rq.push_back(e);
      @(posedge ref_clk);
      reg_rd <= 0;
   endtask
   task automatic acc(logic [1:0] s, logic h, logic [3:0] e);
      int k;
      logic [22:0] a;
      a = 23'($random(seed));
      a[15] = h;
      @(posedge ref_clk);
      acc_req <= 1;
      acc_space <= s;
      acc_addr <= a;
      aq.push_back(e);
      @(posedge ref_clk);
      acc_req <= 0;
      for (k = 0; k < 40 && acc_done !== 1'b1; k++) @(negedge ref_clk);
      if (k == 40) chk_lvl("acc_done", 1'b1, 1'b0);
      @(posedge ref_clk);
   endtask
   //////////////////////////////////////////////////////////////////////////
   // results leave in order; each takes the oldest note
   always @(posedge ref_clk) begin
      if (rd_d) chk_rd(rq.pop_front(), reg_rdata);
      rd_d <= reg_rd;
      // own variable: the stimulus keeps its register image in cnt
      if (acc_done === 1'b1) begin
         ew = aq.pop_front();
         chk_acc(ew, acc_waits);
         chk_hold({1'b0, ew}, busy_seen);
      end
   end
   // watchdog well beyond the planned run
   initial begin
      #400000;
      miscompares++;
      end_of_test();
   end
   initial begin
      repeat (12) @(posedge ref_clk);
      resetn <= 1;
      rd(EWG_CNT_ADDR, 16'h7fff);
      rd(EWG_MUL_ADDR, 16'h0000);
      rd(10'h3fc, 16'h0000);
      acc(2'b01, 0, 4'h7);
      acc(2'b00, 1, 4'h7);
      wr(EWG_MUL_ADDR, 16'hffff);
      rd(EWG_MUL_ADDR, 16'h0001);
      for (int i = 0; i < 8; i++) begin
         cnt = $random(seed);
         cnt[15] = i[1];
         mul = $random(seed);
         mul[0] = i[0];
         wr(EWG_CNT_ADDR, cnt);
         wr(EWG_MUL_ADDR, mul);
         rd(EWG_CNT_ADDR, cnt);
         rd(EWG_MUL_ADDR, {15'h0000, mul[0]});
         for (int s = 0; s < 4; s++)
            for (int h = 0; h < 2; h++)
               acc(s[1:0], h[0], exp_w(cnt, mul[0], s[1:0], h[0]));
      end
      wr(EWG_CNT_ADDR, 16'h0000);
      @(negedge ref_clk);
      chk_lvl("gen_clk_gated", 1'b1, gen_clk_gated);
      acc(2'b10, 1, 4'h0);
      end_of_test();
   end
endmodule
